// file: verilog/nvbsp_pkg.sv
// Package for the host-side controller of a byte-wide nonvolatile SRAM port.
// Holds widths, pin timing counts and reset zero values for the host.
// Assumes a 100 MHz system clock.
package nvbsp_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int DEPTH = 32768;
    localparam int CLK_PERIOD_NS = 10;
    // Access time of the slowest grade, as printed.
    localparam int ACCESS_NS = 45;
    // Output disable to bus float, as printed.
    localparam int FLOAT_NS = 15;
    // Least time rounds up to whole cycles, never below one.
    localparam int ACCESS_CYC =
        (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_CYC =
        (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAVE_PULSE_CYC = 2;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [14:0] ADDR_ZERO = 15'h0000;
endpackage : nvbsp_pkg

// file: verilog/nvbsp_sync.sv
// Three-flop synchroniser for a pin level with agreement filter.
// Assumes a single system clock; the pin is asynchronous to it.
`timescale 1ns/10ps
module nvbsp_sync (
    input wire logic i_sys_clk, // System clock.
    input wire logic i_rst, // Synchronous reset, high.
    input wire logic i_pin, // Asynchronous pin level.
    output logic o_level // Filtered level.
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // The first flop is read only by the second, to contain metastability.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // A change counts only once the second and third flops agree.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_level <= 1'b1;
        end else if (s2_r == s3_r) begin
            o_level <= s3_r;
        end
    end
endmodule : nvbsp_sync

// file: verilog/nvbsp_host.sv
// Host controller that drives a byte-wide nonvolatile SRAM through its pins.
// Assumes the memory sits on the pins below and that the board resolves the
// data and save/busy wires from the enables.
`timescale 1ns/10ps
module nvbsp_host #(
    parameter int ACC_CYC = nvbsp_pkg::ACCESS_CYC, // Access wait cycles.
    parameter int FLT_CYC = nvbsp_pkg::FLOAT_CYC // Bus float cycles.
) (
    input wire logic i_sys_clk, // System clock, 100 MHz.
    input wire logic i_rst, // Synchronous reset, high.
    input wire logic i_req, // Request valid.
    input wire logic i_wr, // 1 write, 0 read.
    input wire logic i_save, // Request a hardware save.
    input wire logic [14:0] i_cell_index, // Byte address.
    input wire logic [7:0] i_wdata, // Write byte.
    output logic o_ready, // Idle and may take a request.
    output logic o_done, // One-cycle end of access.
    output logic [7:0] o_rdata, // Read byte.
    output logic o_busy, // Device saving.
    output logic [14:0] o_cell_index, // Address pins.
    output logic o_sel_n, // Unit select, low.
    output logic o_wr_n, // Write strobe, low.
    output logic o_oe_n, // Output drive enable, low.
    input wire logic [7:0] i_byte_lanes, // Data pins in.
    output logic [7:0] o_byte_lanes, // Data pins out.
    output logic o_byte_lanes_oe, // High while host drives data.
    input wire logic i_hw_nv_save_busy_n, // Save/busy pin in.
    output logic o_hw_nv_save_busy_n, // Save/busy pin out (low).
    output logic o_hw_nv_save_busy_n_oe // High while host pulls low.
);
    typedef enum {NVBSP_IDLE, NVBSP_RD, NVBSP_WR, NVBSP_FLOAT,
        NVBSP_SAVE, NVBSP_SWAIT} nvbsp_state_t;
    nvbsp_state_t state_r;
    logic [3:0] cnt_r;
    logic busy_lvl;
    // All checks below run on the system clock and rest during reset.
    default clocking cb_sys @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////
    // Save/busy pin sampled through three flops; it idles high by pull-up.
    nvbsp_sync u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_pin(i_hw_nv_save_busy_n),
        .o_level(busy_lvl)
    );
    assign o_busy = ~busy_lvl;

    // Counter load value, cut to the counter width.
    function automatic logic [3:0] cyc4(input int n);
        cyc4 = n[3:0];
    endfunction : cyc4

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer. A save in progress blocks new accesses.
    // Software save and restore are runs of plain reads.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_r <= NVBSP_IDLE;
            cnt_r <= nvbsp_pkg::CNT_ZERO;
        end else begin
            case (state_r)
                NVBSP_IDLE: begin
                    if (i_save) begin
                        state_r <= NVBSP_SAVE;
                        cnt_r <= cyc4(nvbsp_pkg::SAVE_PULSE_CYC);
                    end else if (i_req && busy_lvl) begin
                        state_r <= i_wr ? NVBSP_WR : NVBSP_RD;
                        cnt_r <= cyc4(ACC_CYC);
                    end
                end
                NVBSP_RD, NVBSP_WR: begin
                    if (cnt_r == 4'h1) begin
                        state_r <= NVBSP_FLOAT;
                        cnt_r <= cyc4(FLT_CYC);
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                NVBSP_FLOAT: begin
                    if (cnt_r == 4'h1) begin
                        state_r <= NVBSP_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                NVBSP_SAVE: begin
                    if (cnt_r == 4'h1) begin
                        state_r <= NVBSP_SWAIT;
                        cnt_r <= cyc4(4);
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                default: begin
                    // Let the pin settle, then wait out the save.
                    if (cnt_r != 4'h0) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else if (busy_lvl) begin
                        state_r <= NVBSP_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and write data latched at the start of an access.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_cell_index <= nvbsp_pkg::ADDR_ZERO;
            o_byte_lanes <= nvbsp_pkg::DATA_ZERO;
        end else if (state_r == NVBSP_IDLE && i_req && busy_lvl &&
                !i_save) begin
            o_cell_index <= i_cell_index;
            o_byte_lanes <= i_wdata;
        end
    end

    // Strobes come from flops so the pins never glitch.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_sel_n <= 1'b1;
            o_wr_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_byte_lanes_oe <= 1'b0;
            o_hw_nv_save_busy_n_oe <= 1'b0;
        end else begin
            o_sel_n <= !(state_nxt_acc());
            o_wr_n <= !(state_nxt() == NVBSP_WR);
            o_oe_n <= !(state_nxt() == NVBSP_RD);
            o_byte_lanes_oe <= (state_nxt() == NVBSP_WR);
            o_hw_nv_save_busy_n_oe <= (state_nxt() == NVBSP_SAVE);
        end
    end
    assign o_hw_nv_save_busy_n = 1'b0;

    // Next state as seen by the strobe flops.
    function automatic nvbsp_state_t state_nxt();
        nvbsp_state_t s;
        s = state_r;
        if (state_r == NVBSP_IDLE) begin
            if (i_save) begin
                s = NVBSP_SAVE;
            end else if (i_req && busy_lvl) begin
                s = i_wr ? NVBSP_WR : NVBSP_RD;
            end
        end else if (state_r != NVBSP_SWAIT && cnt_r == 4'h1) begin
            s = (state_r == NVBSP_SAVE) ? NVBSP_SWAIT :
                (state_r == NVBSP_FLOAT) ? NVBSP_IDLE : NVBSP_FLOAT;
        end
        state_nxt = s;
    endfunction : state_nxt

    function automatic logic state_nxt_acc();
        state_nxt_acc = (state_nxt() == NVBSP_RD) ||
            (state_nxt() == NVBSP_WR);
    endfunction : state_nxt_acc

    ////////////////////////////////////////////////////////////////////////
    // Read byte captured at the end of the access window; done pulses once.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rdata <= nvbsp_pkg::DATA_ZERO;
            o_done <= 1'b0;
        end else begin
            o_done <= (state_r == NVBSP_RD || state_r == NVBSP_WR) &&
                cnt_r == 4'h1;
            if (state_r == NVBSP_RD && cnt_r == 4'h1) begin
                o_rdata <= i_byte_lanes;
            end
        end
    end
    // Restore at power up and power-loss save happen inside the device;
    // the host only sees them as busy time.
    assign o_ready = (state_r == NVBSP_IDLE) && busy_lvl;

    ////////////////////////////////////////////////////////////////////////
    // A write pulse needs the data drive on and the read buffers off.
    a_wr_strobe_oe: assert property (
        !o_wr_n |-> o_oe_n && o_byte_lanes_oe && !o_sel_n)
        else $error("write strobe without drive");
    a_rd_no_drive: assert property (
        !o_oe_n |-> o_wr_n && !o_byte_lanes_oe)
        else $error("host drives data during read");
    a_sel_covers: assert property (
        (!o_oe_n || !o_wr_n) |-> !o_sel_n)
        else $error("strobe without select");
    a_no_start_busy: assert property (
        (state_r == NVBSP_IDLE && !busy_lvl && !i_save) |=> o_sel_n)
        else $error("access started while busy");
    sequence s_save_req;
        state_r == NVBSP_IDLE && i_save;
    endsequence
    sequence s_save_pulse;
        o_hw_nv_save_busy_n_oe [*2] ##1 !o_hw_nv_save_busy_n_oe;
    endsequence
    a_save_pulse: assert property (
        s_save_req |=> s_save_pulse)
        else $error("save pulse length wrong");
    a_done_after: assert property (
        (state_r == NVBSP_IDLE && i_req && busy_lvl && !i_save)
        |-> ##[1:15] o_done)
        else $error("access never completes");
    a_addr_stable: assert property (
        (!o_sel_n && $past(!o_sel_n)) |-> $stable(o_cell_index))
        else $error("address moved during access");
    a_busy_map: assert property (
        o_busy |-> !o_ready)
        else $error("ready while busy");
    // Five edges of a steady pin are enough for the three flops to settle.
    a_busy_follow: assert property (
        (!i_hw_nv_save_busy_n) [*5] |-> o_busy)
        else $error("busy output missed a low pin");
    a_idle_level: assert property (
        (i_hw_nv_save_busy_n) [*5] |-> !o_busy)
        else $error("busy output stuck after pin release");
endmodule : nvbsp_host

// file: sim/nvbsp_mem_model.sv
// Behavioural model of the byte-wide nonvolatile SRAM behind the host.
// Assumes the bench resolves the data and save/busy wires from all enables.
`timescale 1ns/10ps
module nvbsp_mem_model #(
    parameter int SAVE_NS = 200 // Save length, a plain bench choice.
) (
    input wire logic i_pwr_ok, // Supply present.
    input wire logic i_sel_n, // Unit select, low.
    input wire logic i_wr_n, // Write strobe, low.
    input wire logic i_oe_n, // Output drive enable, low.
    input wire logic [14:0] i_cell_index, // Address pins.
    input wire logic [7:0] i_byte_lanes, // Resolved data wire.
    input wire logic i_hw_nv_save_busy_n, // Resolved save/busy wire.
    output logic [7:0] o_byte_lanes, // Data driven by the memory.
    output logic o_byte_lanes_oe, // High while the memory drives data.
    output logic o_busy_oe // High while the memory pulls save/busy low.
);
    logic [7:0] sram_r [0:32767];
    logic [7:0] nv_r [0:32767];
    logic [14:0] lat_r;
    ////////////////////////////////////////////////////////////////////////
    // Latch the index just after select falls, as the host moves both at once.
    always @(negedge i_sel_n) begin
        #1;
        lat_r = i_cell_index;
    end
    // Store 5 ns into the pulse so the data wire has settled; ignored while saving.
    always @(negedge i_wr_n) begin
        #5;
        if (!i_sel_n && !i_wr_n && !o_busy_oe) begin
            sram_r[lat_r] = i_byte_lanes;
        end
    end
    // Drive data only for a selected read; otherwise let the wire float.
    assign o_byte_lanes_oe =
        !i_sel_n && !i_oe_n && i_wr_n && !o_busy_oe;
    assign o_byte_lanes = sram_r[i_cell_index];
    ////////////////////////////////////////////////////////////////////////
    // A low pulse from outside starts a save; the pin stays low until done.
    // The software trigger would enter the same path.
    initial o_busy_oe = 1'b0;
    always @(negedge i_hw_nv_save_busy_n) begin
        if (!o_busy_oe) begin
            o_busy_oe = 1'b1;
            #SAVE_NS;
            nv_r = sram_r;
            o_busy_oe = 1'b0;
        end
    end
    // Supply loss saves and scrambles the array; return restores it.
    always @(negedge i_pwr_ok) begin
        nv_r = sram_r;
        foreach (sram_r[i]) begin
            sram_r[i] = 8'hee;
        end
    end
    always @(posedge i_pwr_ok) begin
        sram_r = nv_r;
    end
endmodule : nvbsp_mem_model

// file: sim/tb_nonvolatile_byte_sram_port.sv
// Self-checking bench for the host controller with a memory model.
// Assumes the save/busy wire has a pull-up and the data wire none.
`timescale 1ns/10ps
module tb_nonvolatile_byte_sram_port;
    logic clk, rst, req, wr, save, pwr_ok, ready, done, busy;
    logic sel_n, wr_n, oe_n, h_oe, h_hsb, h_hsb_oe, d_oe, d_busy;
    logic [14:0] idx, cidx;
    logic [7:0] wdata, rdata, h_d, d_d;
    wire logic [7:0] lanes_w;
    wire logic hsb_w;
    int miscompares = 0;
    int comparisons = 0;
    // A floating data wire shows a pattern that moves every half cycle.
    assign lanes_w = h_oe ? h_d : (d_oe ? d_d : (8'ha5 ^ {8{clk}}));
    assign hsb_w = ((h_hsb_oe && !h_hsb) || d_busy) ? 1'b0 : 1'b1;
    nvbsp_host dut (.i_sys_clk(clk), .i_rst(rst), .i_req(req), .i_wr(wr),
        .i_save(save), .i_cell_index(idx), .i_wdata(wdata), .o_ready(ready),
        .o_done(done), .o_rdata(rdata), .o_busy(busy), .o_cell_index(cidx),
        .o_sel_n(sel_n), .o_wr_n(wr_n), .o_oe_n(oe_n), .i_byte_lanes(lanes_w),
        .o_byte_lanes(h_d), .o_byte_lanes_oe(h_oe),
        .i_hw_nv_save_busy_n(hsb_w), .o_hw_nv_save_busy_n(h_hsb),
        .o_hw_nv_save_busy_n_oe(h_hsb_oe));
    nvbsp_mem_model u_mem (.i_pwr_ok(pwr_ok), .i_sel_n(sel_n), .i_wr_n(wr_n),
        .i_oe_n(oe_n), .i_cell_index(cidx), .i_byte_lanes(lanes_w),
        .i_hw_nv_save_busy_n(hsb_w), .o_byte_lanes(d_d),
        .o_byte_lanes_oe(d_oe), .o_busy_oe(d_busy));
    ////////////////////////////////////////////////////////////////////////
    // Compare one value and count it.
    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    // Wait for the idle state; a wait that runs out counts as a mismatch.
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(ready, 1'b1);
    endtask : wait_ready
    // One access; strobes are judged in their last low cycle, and the
    // done pulse in the cycle after, when the strobes have gone high.
    task automatic access(input logic w, input logic [14:0] a,
        input logic [7:0] d, output logic [7:0] q);
        wait_ready();
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        idx <= a;
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check(done, 1'b0);
        check(sel_n, 1'b0);
        check(cidx, a);
        check(wr_n, !w);
        check(oe_n, w);
        check(h_oe, w);
        @(posedge clk);
        #1;
        check(done, 1'b1);
        q = rdata;
        check(oe_n, 1'b1);
    endtask : access
    ////////////////////////////////////////////////////////////////////////
    // Both ends of the index range, written back to back, then read.
    task automatic t_ends();
        logic [7:0] q;
        access(1'b1, 15'h0000, 8'h3c, q);
        access(1'b1, 15'h7fff, 8'hc3, q);
        access(1'b0, 15'h0000, 8'h00, q);
        check(q, 8'h3c);
        access(1'b0, 15'h7fff, 8'h00, q);
        check(q, 8'hc3);
    endtask : t_ends
    // Hardware save: pin pulled, busy seen, requests held off until free.
    task automatic t_save();
        // The save request is only taken in idle, so wait for it first.
        wait_ready();
        @(posedge clk);
        save <= 1'b1;
        @(posedge clk);
        save <= 1'b0;
        @(posedge clk);
        #1;
        check(h_hsb_oe, 1'b1);
        repeat (6) @(posedge clk);
        #1;
        check(busy, 1'b1);
        repeat (5) begin
            @(posedge clk);
            req <= 1'b1;
            #1;
            check(sel_n, 1'b1);
            check(ready, 1'b0);
        end
        @(posedge clk);
        req <= 1'b0;
        wait_ready();
        check(busy, 1'b0);
    endtask : t_save
    // Supply drop and return keeps a written byte.
    task automatic t_power();
        logic [7:0] q;
        access(1'b1, 15'h1234, 8'h96, q);
        @(posedge clk);
        pwr_ok <= 1'b0;
        repeat (3) @(posedge clk);
        pwr_ok <= 1'b1;
        access(1'b0, 15'h1234, 8'h00, q);
        check(q, 8'h96);
    endtask : t_power
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // The whole run needs well under a thousand cycles.
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
    initial begin
        {rst, req, wr, save, pwr_ok, idx, wdata} = {5'h11, 15'h0000, 8'h00};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check(ready, 1'b1);
        t_ends();
        t_save();
        t_power();
        final_report();
    end
endmodule : tb_nonvolatile_byte_sram_port
